// ---- threshold_gain_regs.svh ----
// Purpose: offsets, field positions and reset values of the threshold and gain registers
// Assumes: byte-wide registers behind the serial register port
// Notes:   definitions only
`ifndef THRESHOLD_GAIN_REGS_SVH
`define THRESHOLD_GAIN_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_DISCARD_COUNT_LOW 8'h10
`define OFS_THRESHOLD_HIGH 8'h11
`define OFS_THRESHOLD_LOW 8'h12
`define OFS_AMP_GAIN_CTRL 8'h13

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_DISCARD_COUNT_LOW 8'h00
`define RST_THRESHOLD_HIGH 8'h00
`define RST_THRESHOLD_LOW 8'h00
`define RST_AMP_GAIN_CTRL 8'h50
`define RST_UNMAPPED_READ 8'h00

// ----------------------------------------------------------------
// current-channel gain field and its decoded gains
// ----------------------------------------------------------------
`define CUR_GAIN_MSB 7
`define CUR_GAIN_LSB 6
`define CUR_GAIN_RST 2'h1
`define GAIN_CODE0 7'h05
`define GAIN_CODE1 7'h19
`define GAIN_CODE2 7'h28
`define GAIN_CODE3 7'h64

`endif

// ---- threshold_gain_pkg.sv ----
// Purpose: types shared by the threshold and gain register files
// Assumes: byte-wide register port
// Notes:   constants live in threshold_gain_regs.svh
package threshold_gain_pkg;

  // ----------------------------------------------------------------
  // register access request from the serial port logic
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;    // one-cycle write strobe
    logic       rd;    // one-cycle read strobe
    logic [7:0] addr;  // register offset
    logic [7:0] wdata; // write data
  } reg_req_t;

  typedef logic [1:0] gain_code_t;
  typedef logic [6:0] gain_factor_t;

endpackage

// ---- cfg_byte_reg.sv ----
// Purpose: one byte-wide read/write configuration register
// Assumes: synchronous write strobe on the device clock
// Notes:   reset value is a parameter
`timescale 1ns/10ps

module cfg_byte_reg #(
  parameter logic [7:0] RST_VAL = 8'h00
) (
  input  wire logic       clk_i,   // device clock
  input  wire logic       rst_n_i, // synchronised reset, active low
  input  wire logic       wr_i,    // write strobe for this register
  input  wire logic [7:0] wdata_i, // write data
  output logic      [7:0] q_o      // stored value
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] val_ff;
  logic [7:0] nxt_val;

  // hold unless written
  assign nxt_val = wr_i ? wdata_i : val_ff;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      val_ff <= RST_VAL;
    end else begin
      val_ff <= nxt_val;
    end
  end

  assign q_o = val_ff;

endmodule

// ---- threshold_gain_registers.sv ----
// Purpose: threshold, discard count and current gain registers of the acquisition device
// Assumes: register strobes come from serial port logic on ref_clk_i
// Notes:   comparison runs only in threshold trigger mode
//
// What this block does
// RQ1 - 0x10 holds discard count low byte
// RQ2 - 0x11 gives threshold upper eight bits
// RQ3 - 0x12 gives threshold lower eight bits
// RQ4 - gain codes decode to 5, 25, 40, 100
// RQ5 - reset: gain 01, ctrl 0x50, others zero
// RQ6 - compare threshold only in threshold trigger mode
`timescale 1ns/10ps
`include "threshold_gain_regs.svh"

module threshold_gain_registers
  import threshold_gain_pkg::*;
(
  input  wire logic         ref_clk_i,                // 10 MHz device clock
  input  wire logic         arst_n_i,                 // async reset, active low
  input  wire reg_req_t     req_i,                    // register access request
  input  wire logic         threshold_trigger_mode_i, // threshold mode selected
  input  wire logic         result_valid_i,           // new current result
  input  wire logic  [15:0] result_i,                 // current result
  output logic        [7:0] rdata_o,                  // read data
  output logic        [7:0] discard_count_low_o,      // discard count low byte
  output logic       [15:0] threshold_o,              // 16-bit current threshold
  output gain_code_t        gain_code_o,              // current gain code
  output gain_factor_t      gain_factor_o,            // decoded current gain
  output logic        [1:0] volt_gain_code_o,         // voltage gain bits, passed on
  output logic              threshold_hit_o           // result above threshold
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_n_ff;

  // assert at once, release two edges later to avoid recovery hazards
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire sel_discard = (req_i.addr == `OFS_DISCARD_COUNT_LOW);
  wire sel_thr_hi = (req_i.addr == `OFS_THRESHOLD_HIGH);
  wire sel_thr_lo = (req_i.addr == `OFS_THRESHOLD_LOW);
  wire sel_gain = (req_i.addr == `OFS_AMP_GAIN_CTRL);
  wire wr_discard = req_i.wr & sel_discard;
  wire wr_thr_hi = req_i.wr & sel_thr_hi;
  wire wr_thr_lo = req_i.wr & sel_thr_lo;
  wire wr_gain = req_i.wr & sel_gain;

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] discard_q;
  logic [7:0] thr_hi_q;
  logic [7:0] thr_lo_q;
  logic [7:0] gain_q;

  // discard count low byte
  cfg_byte_reg #(.RST_VAL(`RST_DISCARD_COUNT_LOW)) u_discard ( // [RQ1] [RQ5]
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_ff),
    .wr_i(wr_discard),
    .wdata_i(req_i.wdata),
    .q_o(discard_q)
  );

  // threshold upper byte
  cfg_byte_reg #(.RST_VAL(`RST_THRESHOLD_HIGH)) u_thr_hi ( // [RQ2] [RQ5]
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_ff),
    .wr_i(wr_thr_hi),
    .wdata_i(req_i.wdata),
    .q_o(thr_hi_q)
  );

  // threshold lower byte
  cfg_byte_reg #(.RST_VAL(`RST_THRESHOLD_LOW)) u_thr_lo ( // [RQ3] [RQ5]
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_ff),
    .wr_i(wr_thr_lo),
    .wdata_i(req_i.wdata),
    .q_o(thr_lo_q)
  );

  // amplifier gain control, current gain code 01 after reset
  cfg_byte_reg #(.RST_VAL(`RST_AMP_GAIN_CTRL)) u_gain ( // [RQ5]
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_ff),
    .wr_i(wr_gain),
    .wdata_i(req_i.wdata),
    .q_o(gain_q)
  );

  // the two threshold bytes form one word, high byte first
  assign discard_count_low_o = discard_q;            // [RQ1]
  assign threshold_o = {thr_hi_q, thr_lo_q};         // [RQ2] [RQ3]
  assign gain_code_o = gain_q[`CUR_GAIN_MSB:`CUR_GAIN_LSB];
  assign volt_gain_code_o = gain_q[5:4];

  // ----------------------------------------------------------------
  // gain decode, registered so the output stays a flop
  // ----------------------------------------------------------------
  gain_factor_t gain_factor_ff;
  gain_factor_t nxt_gain_factor;

  always_comb begin
    unique case (gain_code_o)
      2'h0: nxt_gain_factor = `GAIN_CODE0; // [RQ4]
      2'h1: nxt_gain_factor = `GAIN_CODE1; // [RQ4]
      2'h2: nxt_gain_factor = `GAIN_CODE2; // [RQ4]
      2'h3: nxt_gain_factor = `GAIN_CODE3; // [RQ4]
    endcase
  end

  // reset value matches the reset gain code, no glitch at release
  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      gain_factor_ff <= `GAIN_CODE1; // [RQ5]
    end else begin
      gain_factor_ff <= nxt_gain_factor;
    end
  end

  assign gain_factor_o = gain_factor_ff;

  // ----------------------------------------------------------------
  // threshold comparison
  // ----------------------------------------------------------------
  logic hit_ff;
  logic nxt_hit;
  wire above = (result_i > threshold_o);

  // outside threshold mode the register contents have no effect
  assign nxt_hit = !threshold_trigger_mode_i ? 1'b0 :       // [RQ6]
                   result_valid_i ? above : hit_ff;         // [RQ6]

  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      hit_ff <= 1'b0;
    end else begin
      hit_ff <= nxt_hit;
    end
  end

  assign threshold_hit_o = hit_ff;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] rdata_ff;
  wire [7:0] rd_mux = sel_discard ? discard_q :
                      sel_thr_hi ? thr_hi_q :
                      sel_thr_lo ? thr_lo_q :
                      sel_gain ? gain_q : `RST_UNMAPPED_READ;

  // data held until the next read strobe; reads have no side effect
  always_ff @(posedge ref_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rdata_ff <= 8'h00;
    end else if (req_i.rd) begin
      rdata_ff <= rd_mux;
    end
  end

  assign rdata_o = rdata_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  function automatic gain_factor_t gain_of(input gain_code_t c);
    gain_of = (c == 2'h0) ? 7'h05 : (c == 2'h1) ? 7'h19 : (c == 2'h2) ? 7'h28 : 7'h64;
  endfunction

  sequence s_wr_thr_hi;
    req_i.wr && req_i.addr == 8'h11;
  endsequence

  sequence s_wr_thr_lo;
    req_i.wr && req_i.addr == 8'h12;
  endsequence

  property p_discard_write;
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
      (req_i.wr && req_i.addr == 8'h10) |=> (discard_count_low_o == $past(req_i.wdata));
  endproperty
  a_discard_write: assert property (p_discard_write) // [RQ1]
    else $error("discard count low byte not written");

  property p_thr_hi_write;
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
      s_wr_thr_hi |=> (threshold_o[15:8] == $past(req_i.wdata));
  endproperty
  a_thr_hi_write: assert property (p_thr_hi_write) // [RQ2]
    else $error("threshold high byte wrong");

  property p_thr_lo_write;
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
      s_wr_thr_lo |=> (threshold_o == {$past(thr_hi_q), $past(req_i.wdata)});
  endproperty
  a_thr_lo_write: assert property (p_thr_lo_write) // [RQ3]
    else $error("threshold low byte wrong");

  property p_gain_decode;
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
      ##1 (gain_factor_o == gain_of($past(gain_code_o)));
  endproperty
  a_gain_decode: assert property (p_gain_decode) // [RQ4]
    else $error("gain decode mismatch");

  property p_reset_values;
    @(posedge ref_clk_i)
      $rose(rst_n_ff) |-> (gain_q == 8'h50 && gain_code_o == 2'h1 && threshold_o == 16'h0000
                           && discard_count_low_o == 8'h00 && gain_factor_o == 7'h19);
  endproperty
  a_reset_values: assert property (p_reset_values) // [RQ5]
    else $error("register reset values wrong");

  property p_no_hit_outside_mode;
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
      !threshold_trigger_mode_i |=> !threshold_hit_o;
  endproperty
  a_no_hit_outside_mode: assert property (p_no_hit_outside_mode) // [RQ6]
    else $error("threshold hit outside threshold mode");

  property p_hit_in_mode;
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
      (threshold_trigger_mode_i && result_valid_i) |=> (threshold_hit_o == ($past(result_i) > $past(threshold_o)));
  endproperty
  a_hit_in_mode: assert property (p_hit_in_mode) // [RQ6]
    else $error("threshold comparison wrong");

  property p_read_gain;
    @(posedge ref_clk_i) disable iff (!rst_n_ff)
      (req_i.rd && req_i.addr == 8'h13) |=> (rdata_o == $past(gain_q));
  endproperty
  a_read_gain: assert property (p_read_gain) // [RQ5]
    else $error("gain register read wrong");

endmodule

// ---- host_port_model.sv ----
// Purpose: host side of the serial register port, as seen after deserialising
// Assumes: caller enters each task just after a rising edge
// Notes:   idle address and data wander so stale values never look valid
`timescale 1ns/10ps

module host_port_model
  import threshold_gain_pkg::*;
(
  input  wire logic clk_i, // device clock
  output reg_req_t  req_o  // request towards the register port
);
  // ----------------------------------------------------------------
  // request tasks
  // ----------------------------------------------------------------
  initial req_o = '0;

  // one request held for exactly one rising edge, never released early
  task automatic xfer(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    req_o = {w, r, a, d};
    @(posedge clk_i);
    #2;
  endtask

  // strobes low, address and data scrambled to catch use of stale fields
  task automatic idle();
    req_o = {1'b0, 1'b0, 8'($urandom), 8'($urandom)};
    @(posedge clk_i);
    #2;
  endtask
endmodule

// ---- threshold_gain_registers_tb.sv ----
// Purpose: self-checking bench for the threshold and gain registers
// Assumes: host model drives the port, bench drives the result stream
// Notes:   reads and compares are checked by a monitor from queued notes
`timescale 1ns/10ps

module threshold_gain_registers_tb;
  import threshold_gain_pkg::*;

  // ----------------------------------------------------------------
  // signals and bookkeeping
  // ----------------------------------------------------------------
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic mode = 1'b0;
  logic valid = 1'b0;
  logic [15:0] result = 16'h0000;
  reg_req_t req;
  logic [7:0] rdata, dcl;
  logic [15:0] thr;
  gain_code_t gc;
  gain_factor_t gf;
  logic [1:0] vg;
  logic hit, mon_rd, mon_cmp;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [7:0] rq[$];
  logic hq[$];
  gain_factor_t gains[4] = '{7'd5, 7'd25, 7'd40, 7'd100};

  initial begin
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  host_port_model host (.clk_i(ref_clk_i), .req_o(req));

  threshold_gain_registers DUT (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .req_i(req),
    .threshold_trigger_mode_i(mode), .result_valid_i(valid), .result_i(result),
    .rdata_o(rdata), .discard_count_low_o(dcl), .threshold_o(thr), .gain_code_o(gc),
    .gain_factor_o(gf), .volt_gain_code_o(vg), .threshold_hit_o(hit)
  );

  // ----------------------------------------------------------------
  // compare, verdict and hang guard
  // ----------------------------------------------------------------
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // whole run needs about 50 cycles, so this only trips on a hang
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // monitor: results appear one cycle after the request that caused them
  always @(posedge ref_clk_i) begin
    mon_rd = req.rd;
    mon_cmp = valid & mode;
    #1;
    if (mon_rd) cmp("rdata_o", 16'(rq.pop_front()), 16'(rdata));
    if (mon_cmp) cmp("threshold_hit_o", 16'(hq.pop_front()), 16'(hit));
  end

  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] ev[4];
    logic [15:0] t;
    logic [15:0] rv[6];
    void'($urandom(32'h03f3));
    repeat (8) @(posedge ref_clk_i);
    #2;
    arst_n_i = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #2;
    // reset state at the pins, then by reading back to back
    cmp("gain_code_o", 16'h0001, 16'(gc));
    cmp("gain_factor_o", 16'd25, 16'(gf));
    cmp("threshold_o", 16'h0000, thr);
    cmp("discard_count_low_o", 16'h0000, 16'(dcl));
    ev = '{8'h00, 8'h00, 8'h00, 8'h50};
    for (int i = 0; i < 4; i++) begin
      rq.push_back(ev[i]);
      host.xfer(1'b0, 1'b1, 8'h10 + 8'(i), 8'($urandom));
    end
    // random contents, a stray write to an unmapped place, full read back
    t = 16'($urandom_range(16'hfffe, 1));
    ev = '{8'($urandom), t[15:8], t[7:0], 8'($urandom)};
    for (int i = 0; i < 4; i++) host.xfer(1'b1, 1'b0, 8'h10 + 8'(i), ev[i]);
    host.xfer(1'b1, 1'b0, 8'h14, 8'($urandom));
    for (int i = 0; i < 5; i++) begin
      rq.push_back(i < 4 ? ev[i] : 8'h00);
      host.xfer(1'b0, 1'b1, 8'h10 + 8'(i), 8'($urandom));
    end
    host.idle();
    cmp("discard_count_low_o", 16'(ev[0]), 16'(dcl));
    cmp("threshold_o", t, thr);
    cmp("volt_gain_code_o", 16'(ev[3][5:4]), 16'(vg));
    // every gain code, decoded gain lags the code by a cycle
    for (int c = 0; c < 4; c++) begin
      ev[3] = {2'(c), 6'($urandom)};
      host.xfer(1'b1, 1'b0, 8'h13, ev[3]);
      host.idle();
      host.idle();
      cmp("gain_code_o", 16'(c), 16'(gc));
      cmp("gain_factor_o", 16'(gains[c]), 16'(gf));
    end
    // threshold edges: strictly above hits, equal does not
    rv = '{t + 16'h1, t, t - 16'h1, 16'hffff, 16'h0000, t + 16'h1};
    for (int i = 0; i < 6; i++) begin
      mode = 1'b1;
      valid = 1'b1;
      result = rv[i];
      hq.push_back(rv[i] > t);
      @(posedge ref_clk_i);
      #2;
    end
    // a hit stands while no new result arrives
    valid = 1'b0;
    @(posedge ref_clk_i);
    #2;
    cmp("threshold_hit_o", 16'h0001, 16'(hit));
    // leaving the mode clears a standing hit, and outside it results are ignored
    mode = 1'b0;
    @(posedge ref_clk_i);
    #2;
    cmp("threshold_hit_o", 16'h0000, 16'(hit));
    valid = 1'b1;
    result = 16'hffff;
    @(posedge ref_clk_i);
    #2;
    cmp("threshold_hit_o", 16'h0000, 16'(hit));
    valid = 1'b0;
    host.idle();
    finish_test();
  end
endmodule
